/* verilog/cdr_pkg.sv */
// Constants and types of the canceller diagnostic control and reset-mode block
// Contract
// - Instability event clears both canceller coefficient sets
// - Bit 15 set blocks instability coefficient clearing
// - Half-duplex tone clears acoustic, forces receive
// - Full-duplex tone freezes acoustic coefficients
// - Bit 13 clear: acoustic path change clears
// - Bit 12 clear: network path change clears
// - Bits 11 and 10 bypass pre-emphasis filters
// - Bit 9 removes acoustic canceller
// - Bit 8 removes network canceller
// - Bits 7-6 select acoustic sidetone level
// - Bits 5-4 select network sidetone level
// - Reset low powers down, stops oscillator
// - Release: oscillator, 4 ms, clocks, calibration
// - Mode write in window, else cold
// - Decode 0000/0006/8000/8006 as reset modes
// - Mode values also land in registers 0/3; here 0006 is cleared from register 3 at apply, so only 8000/8006 remain
// - Cold reset clears and restores defaults
// - Warm reset keeps canceller coefficients
// - Timer halts operation unless early exit
package cdr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIAG   = 8'h00;
  localparam logic [7:0] ADDR_MODE   = 8'h04;
  localparam logic [7:0] ADDR_REG0   = 8'h08;
  localparam logic [7:0] ADDR_REG3   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // Diagnostic register fields
  // ----------------------------------------------------------------
  localparam int BIT_INST_OFF = 15;
  localparam int BIT_TONE_OFF = 14;
  localparam int BIT_APC_OFF  = 13;
  localparam int BIT_NPC_OFF  = 12;
  localparam int BIT_APF_OFF  = 11;
  localparam int BIT_NPF_OFF  = 10;
  localparam int BIT_AEC_OFF  = 9;
  localparam int BIT_NEC_OFF  = 8;
  localparam int ACOUSTIC_SIDETONE_LEVEL_HI      = 7;
  localparam int ACOUSTIC_SIDETONE_LEVEL_LO      = 6;
  localparam int NETWORK_SIDETONE_LEVEL_HI      = 5;
  localparam int NETWORK_SIDETONE_LEVEL_LO      = 4;

  localparam logic [15:0] DIAG_RST = 16'h0000;
  localparam logic [15:0] REG0_RST = 16'h0000;
  localparam logic [15:0] REG3_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Reset-mode words
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_COLD_TIMED = 16'h0000;
  localparam logic [15:0] MODE_WARM_TIMED = 16'h0006;
  localparam logic [15:0] MODE_COLD_NOW   = 16'h8000;
  localparam logic [15:0] MODE_WARM_NOW   = 16'h8006;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 10_000_000;
  localparam int OSC_START_MS      = 4;
  localparam int OSC_START_CYC     = OSC_START_MS * (CLK_HZ / 1000);
  localparam int RESET_WINDOW_MS   = 20;
  localparam int RESET_WINDOW_CYC  = RESET_WINDOW_MS * (CLK_HZ / 1000);
  localparam int COLD_TIMEOUT_MS   = 20;
  localparam int COLD_TIMEOUT_CYC  = COLD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W             = 24;

  typedef enum logic [0:0] {
    PH_WAIT,
    PH_RUN
  } cdr_phase_t;

  typedef struct packed {
    cdr_phase_t       phase;
    logic [CNT_W-1:0] cnt;
    logic [15:0]      diag;
    logic [15:0]      reg0;
    logic [15:0]      reg3;
    logic             mode_seen;
    logic             warm_sel;
    logic             imm_sel;
    logic             last_warm;
    logic             waitreq;
    logic [31:0]      rdata;
    logic             osc_en;
    logic             pdown;
    logic             clk_run;
    logic             conv_rst;
    logic             cal_start;
    logic             clr_a;
    logic             clr_n;
    logic             freeze_a;
    logic             force_rx;
  } cdr_state_t;

endpackage

/* verilog/cdr_ctrl.sv */
// Diagnostic control register, reset sequencer and Avalon-MM slave
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module cdr_ctrl #(
  parameter int unsigned OSC_CYC  = cdr_pkg::OSC_START_CYC,
  parameter int unsigned WRST_CYC = cdr_pkg::RESET_WINDOW_CYC,
  parameter int unsigned CRST_CYC = cdr_pkg::COLD_TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        instability_evt,
  input  wire logic        tone_detect,
  input  wire logic        acoustic_path_evt,
  input  wire logic        network_path_evt,
  input  wire logic        full_duplex,
  output logic             osc_enable,
  output logic             powerdown,
  output logic             clocks_run,
  output logic             converter_reset,
  output logic             calibrate_start,
  output logic             reset_was_warm,
  output logic             device_running,
  output logic             acoustic_coef_clear,
  output logic             network_coef_clear,
  output logic             acoustic_coef_freeze,
  output logic             force_receive,
  output logic             acoustic_preemph_off,
  output logic             network_preemph_off,
  output logic             acoustic_canceller_off,
  output logic             network_canceller_off,
  output logic      [1:0]  acoustic_sidetone_level,
  output logic      [1:0]  network_sidetone_level
);

  localparam logic [23:0] OSC_N  = 24'(OSC_CYC);
  localparam logic [23:0] WRST_N = 24'(WRST_CYC);
  localparam logic [23:0] CRST_N = 24'(CRST_CYC);

  cdr_pkg::cdr_state_t s_reg;
  cdr_pkg::cdr_state_t s_next;

  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        running;
  logic        window_open;
  logic        mode_wr;
  logic        mode_ok;
  logic [15:0] wdat;
  logic [15:0] status;

  assign req         = avs_read | avs_write;
  assign acc         = req & ~s_reg.waitreq;
  assign wr_acc      = avs_write & ~s_reg.waitreq;
  assign running     = (s_reg.phase == cdr_pkg::PH_RUN);
  assign window_open = ~running & (s_reg.cnt < WRST_N);
  assign wdat        = avs_writedata[15:0];
  assign mode_wr     = wr_acc & (avs_address == cdr_pkg::ADDR_MODE)
                       & (&avs_byteenable[1:0]);
  assign mode_ok     = (wdat == cdr_pkg::MODE_COLD_TIMED)
                       | (wdat == cdr_pkg::MODE_WARM_TIMED)
                       | (wdat == cdr_pkg::MODE_COLD_NOW)
                       | (wdat == cdr_pkg::MODE_WARM_NOW);
  assign status = {8'h00, s_reg.force_rx, s_reg.freeze_a, window_open,
                   s_reg.mode_seen, s_reg.last_warm, s_reg.osc_en,
                   s_reg.clk_run, running};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic apply;
    logic cold;
    apply  = 1'b0;
    cold   = 1'b0;
    s_next = s_reg;
    s_next.conv_rst  = 1'b0;
    s_next.cal_start = 1'b0;
    s_next.clr_a     = 1'b0;
    s_next.clr_n     = 1'b0;
    s_next.freeze_a  = 1'b0;
    s_next.force_rx  = 1'b0;
    // Oscillator runs from the first edge after release
    s_next.osc_en = 1'b1;
    s_next.pdown  = 1'b0;

    // Bus handshake: one wait cycle, then a single-cycle answer
    s_next.waitreq = ~(req & s_reg.waitreq);
    if (req & s_reg.waitreq) begin
      case (avs_address)
        cdr_pkg::ADDR_DIAG:   s_next.rdata = {16'h0000, s_reg.diag};
        cdr_pkg::ADDR_REG0:   s_next.rdata = {16'h0000, s_reg.reg0};
        cdr_pkg::ADDR_REG3:   s_next.rdata = {16'h0000, s_reg.reg3};
        cdr_pkg::ADDR_STATUS: s_next.rdata = {16'h0000, status};
        default:              s_next.rdata = 32'h0000_0000;
      endcase
    end

    // Reset sequencer
    if (!running) begin
      if (s_reg.cnt != 24'hff_ffff) begin
        s_next.cnt = s_reg.cnt + 24'h00_0001;
      end
      // Digital clocks start after the oscillator settles
      if (s_reg.cnt == OSC_N) begin
        s_next.clk_run = 1'b1;
      end
      if (mode_wr & mode_ok & window_open & ~s_reg.mode_seen) begin
        s_next.mode_seen = 1'b1;
        s_next.warm_sel  = wdat[2] & wdat[1];
        s_next.imm_sel   = wdat[15];
      end
      // Operation halts until the timer ends or an early exit
      apply = s_reg.clk_run
              & (s_next.imm_sel | (s_reg.cnt >= CRST_N));
    end

    if (apply) begin
      cold               = ~s_next.warm_sel;
      s_next.phase       = cdr_pkg::PH_RUN;
      s_next.last_warm   = s_next.warm_sel;
      s_next.conv_rst    = 1'b1;
      s_next.cal_start   = 1'b1;
      s_next.diag        = cdr_pkg::DIAG_RST;
      // An immediate mode word may arrive before the clocks run, so it is restored here
      s_next.reg0        = (s_next.imm_sel & ~s_next.warm_sel)
                           ? cdr_pkg::MODE_COLD_NOW : cdr_pkg::REG0_RST;
      s_next.reg3        = (s_next.imm_sel & s_next.warm_sel)
                           ? cdr_pkg::MODE_WARM_NOW : cdr_pkg::REG3_RST;
      // Warm reset leaves both coefficient sets untouched
      s_next.clr_a       = cold;
      s_next.clr_n       = cold;
    end

    // Register writes land after the defaults, so a mode word wins
    if (wr_acc) begin
      case (avs_address)
        cdr_pkg::ADDR_DIAG: begin
          if (avs_byteenable[0]) s_next.diag[7:0]  = wdat[7:0];
          if (avs_byteenable[1]) s_next.diag[15:8] = wdat[15:8];
        end
        cdr_pkg::ADDR_REG0: begin
          if (avs_byteenable[0]) s_next.reg0[7:0]  = wdat[7:0];
          if (avs_byteenable[1]) s_next.reg0[15:8] = wdat[15:8];
        end
        cdr_pkg::ADDR_REG3: begin
          if (avs_byteenable[0]) s_next.reg3[7:0]  = wdat[7:0];
          if (avs_byteenable[1]) s_next.reg3[15:8] = wdat[15:8];
        end
        cdr_pkg::ADDR_MODE: begin
          if (mode_wr & window_open) begin
            if (wdat == cdr_pkg::MODE_COLD_NOW) begin
              s_next.reg0 = wdat;
            end
            if ((wdat == cdr_pkg::MODE_WARM_TIMED)
                | (wdat == cdr_pkg::MODE_WARM_NOW)) begin
              s_next.reg3 = wdat;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Detector reactions, only once the device is running
    if (running) begin
      if (instability_evt & ~s_reg.diag[cdr_pkg::BIT_INST_OFF]) begin
        s_next.clr_a = 1'b1;
        s_next.clr_n = 1'b1;
      end
      if (tone_detect & ~s_reg.diag[cdr_pkg::BIT_TONE_OFF]) begin
        if (full_duplex) begin
          s_next.freeze_a = 1'b1;
        end else begin
          s_next.clr_a    = 1'b1;
          s_next.force_rx = 1'b1;
        end
      end
      if (acoustic_path_evt & ~s_reg.diag[cdr_pkg::BIT_APC_OFF]) begin
        s_next.clr_a = 1'b1;
      end
      if (network_path_evt & ~s_reg.diag[cdr_pkg::BIT_NPC_OFF]) begin
        s_next.clr_n = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg           <= '0;
      s_reg.phase     <= cdr_pkg::PH_WAIT;
      s_reg.diag      <= cdr_pkg::DIAG_RST;
      s_reg.reg0      <= cdr_pkg::REG0_RST;
      s_reg.reg3      <= cdr_pkg::REG3_RST;
      s_reg.waitreq   <= 1'b1;
      // Held reset is powerdown: oscillator stopped
      s_reg.pdown     <= 1'b1;
      s_reg.osc_en    <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata            = s_reg.rdata;
  assign avs_waitrequest         = s_reg.waitreq;
  assign osc_enable              = s_reg.osc_en;
  assign powerdown               = s_reg.pdown;
  assign clocks_run              = s_reg.clk_run;
  assign converter_reset         = s_reg.conv_rst;
  assign calibrate_start         = s_reg.cal_start;
  assign reset_was_warm          = s_reg.last_warm;
  assign device_running          = (s_reg.phase == cdr_pkg::PH_RUN);
  assign acoustic_coef_clear     = s_reg.clr_a;
  assign network_coef_clear      = s_reg.clr_n;
  assign acoustic_coef_freeze    = s_reg.freeze_a;
  assign force_receive           = s_reg.force_rx;
  assign acoustic_preemph_off    = s_reg.diag[cdr_pkg::BIT_APF_OFF];
  assign network_preemph_off     = s_reg.diag[cdr_pkg::BIT_NPF_OFF];
  // Duplex decision logic drops a canceller flagged here
  assign acoustic_canceller_off  = s_reg.diag[cdr_pkg::BIT_AEC_OFF];
  assign network_canceller_off   = s_reg.diag[cdr_pkg::BIT_NEC_OFF];
  assign acoustic_sidetone_level =
    s_reg.diag[cdr_pkg::ACOUSTIC_SIDETONE_LEVEL_HI:cdr_pkg::ACOUSTIC_SIDETONE_LEVEL_LO];
  assign network_sidetone_level  =
    s_reg.diag[cdr_pkg::NETWORK_SIDETONE_LEVEL_HI:cdr_pkg::NETWORK_SIDETONE_LEVEL_LO];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_inst_clear: assert property (
    running & instability_evt & ~s_reg.diag[cdr_pkg::BIT_INST_OFF]
    |=> acoustic_coef_clear & network_coef_clear)
    else $error("instability did not clear both cancellers");

  a_inst_block: assert property (
    running & instability_evt & s_reg.diag[cdr_pkg::BIT_INST_OFF]
    & ~network_path_evt |=> !network_coef_clear)
    else $error("disabled instability still cleared");

  a_tone_half: assert property (
    running & tone_detect & ~full_duplex
    & ~s_reg.diag[cdr_pkg::BIT_TONE_OFF]
    |=> acoustic_coef_clear & force_receive)
    else $error("half-duplex tone not handled");

  a_tone_full: assert property (
    running & tone_detect & full_duplex
    & ~s_reg.diag[cdr_pkg::BIT_TONE_OFF]
    |=> acoustic_coef_freeze & !force_receive)
    else $error("full-duplex tone did not freeze");

  a_apc_clear: assert property (
    running & acoustic_path_evt & ~s_reg.diag[cdr_pkg::BIT_APC_OFF]
    |=> acoustic_coef_clear)
    else $error("acoustic path change not cleared");

  a_npc_clear: assert property (
    running & network_path_evt & ~s_reg.diag[cdr_pkg::BIT_NPC_OFF]
    |=> network_coef_clear)
    else $error("network path change not cleared");

  a_diag_write: assert property (
    wr_acc & (avs_address == cdr_pkg::ADDR_DIAG) & avs_byteenable[1]
    & running |=> acoustic_canceller_off == $past(avs_writedata[9]))
    else $error("diagnostic write not reflected");

  a_osc_delay: assert property (
    $rose(clocks_run) |-> s_reg.cnt == OSC_N + 24'h00_0001)
    else $error("clocks started at wrong time");

  a_imm_cold: assert property (
    mode_wr & window_open & s_reg.clk_run & ~s_reg.mode_seen
    & (wdat == cdr_pkg::MODE_COLD_NOW)
    |=> converter_reset & acoustic_coef_clear & network_coef_clear)
    else $error("immediate cold reset missing");

  a_warm_keep: assert property (
    converter_reset & reset_was_warm |-> !acoustic_coef_clear
    & !network_coef_clear)
    else $error("warm reset cleared coefficients");

  a_timeout_cold: assert property (
    !running & s_reg.clk_run & ~s_reg.mode_seen & (s_reg.cnt >= CRST_N)
    & ~mode_wr |=> converter_reset & !reset_was_warm)
    else $error("default cold reset missing");

  a_bus_answer: assert property (
    req & avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not single cycle");

  c_timed_cold: cover property (!reset_was_warm & $rose(device_running));
  c_warm_now:   cover property (reset_was_warm & $rose(device_running));
  c_inst_hit:   cover property (running & instability_evt ##1 network_coef_clear);
  c_tone_full:  cover property (running & tone_detect & full_duplex ##1 acoustic_coef_freeze);

endmodule

/* tb/cdr_host.sv */
// Host controller model: reset pin and Avalon-MM master
`timescale 1ns/10ps
module cdr_host (
  input  wire logic        clk,
  output logic             arst_n,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    arst_n         = 1'b0;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h3;
  end

  // Pin low for five cycles, then released
  task automatic pulse_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  // Leading edge wait keeps one idle cycle between transfers
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_read      <= rd;
    avs_write     <= !rd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata[15:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the diagnostic control and reset-mode block
`timescale 1ns/10ps
module tb;
  localparam int OSC = 8;
  localparam int CTO = 40;
  localparam int LIMIT = 4000;
  logic        clk = 1'b0;
  logic        arst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        instability_evt, tone_detect, acoustic_path_evt, network_path_evt, full_duplex;
  logic        osc_enable, powerdown, clocks_run, converter_reset, calibrate_start;
  logic        reset_was_warm, device_running, acoustic_coef_clear, network_coef_clear;
  logic        acoustic_coef_freeze, force_receive, acoustic_preemph_off, network_preemph_off;
  logic        acoustic_canceller_off, network_canceller_off;
  logic [1:0]  acoustic_sidetone_level, network_sidetone_level;
  int          cyc = 0, fails = 0, n_compared = 0, n_acl = 0, n_ncl = 0, n_app = 0;
  int          el, a0, n0, p0;
  logic [15:0] modes [6] = '{16'h0000, 16'h0000, 16'h0006, 16'h8000, 16'h8006, 16'h1234};
  logic [15:0] vals [4] = '{16'h0000, 16'h0550, 16'h0aa0, 16'hfff0};
  logic        early, warm;

  always #50 clk = ~clk;

  initial begin
    {instability_evt, tone_detect, acoustic_path_evt, network_path_evt} = 4'h0;
    full_duplex = 1'b0;
  end

  cdr_host host (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  cdr_ctrl #(.OSC_CYC(OSC), .WRST_CYC(CTO), .CRST_CYC(CTO)) dut (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .instability_evt(instability_evt), .tone_detect(tone_detect),
    .acoustic_path_evt(acoustic_path_evt), .network_path_evt(network_path_evt),
    .full_duplex(full_duplex), .osc_enable(osc_enable), .powerdown(powerdown),
    .clocks_run(clocks_run), .converter_reset(converter_reset),
    .calibrate_start(calibrate_start), .reset_was_warm(reset_was_warm),
    .device_running(device_running), .acoustic_coef_clear(acoustic_coef_clear),
    .network_coef_clear(network_coef_clear), .acoustic_coef_freeze(acoustic_coef_freeze),
    .force_receive(force_receive), .acoustic_preemph_off(acoustic_preemph_off),
    .network_preemph_off(network_preemph_off), .acoustic_canceller_off(acoustic_canceller_off),
    .network_canceller_off(network_canceller_off),
    .acoustic_sidetone_level(acoustic_sidetone_level),
    .network_sidetone_level(network_sidetone_level));

  // ----------------------------------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (converter_reset === 1'b1 && calibrate_start === 1'b1) n_app++;
    if (acoustic_coef_clear === 1'b1) n_acl++;
    if (network_coef_clear === 1'b1) n_ncl++;
    if (cyc > LIMIT) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.xfer(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    host.xfer(1'b1, a, 16'h0000, q);
    chk(what, {16'h0000, e}, {16'h0000, q});
  endtask

  // Cycle count is taken from the release edge, so ranges allow a few cycles of slack
  task automatic boot(input logic [15:0] mode, input logic send, input logic timed);
    int t0;
    host.pulse_reset();
    chk("powerdown held", 32'h1, {31'h0, powerdown & ~osc_enable});
    t0 = cyc;
    @(posedge clk);
    @(negedge clk);
    chk("osc after release", 32'h1, {31'h0, osc_enable & ~powerdown});
    if (send && mode != cdr_pkg::MODE_COLD_NOW) wr(cdr_pkg::ADDR_MODE, mode);
    if (timed) wr(cdr_pkg::ADDR_DIAG, 16'hfff0);
    while (clocks_run !== 1'b1) @(posedge clk);
    chk("clock start delay", 32'h1, {31'h0, (cyc - t0 >= OSC) && (cyc - t0 <= OSC + 3)});
    // Immediate cold word sent once clocks run, so it applies at its own answering edge
    if (send && mode == cdr_pkg::MODE_COLD_NOW) wr(cdr_pkg::ADDR_MODE, mode);
    while (device_running !== 1'b1) @(posedge clk);
    el = cyc - t0;
    // Let the pulse counters take the apply edge before they are read
    @(negedge clk);
  endtask

  task automatic det(input logic [3:0] ev, input logic [15:0] dv, input logic fd,
                     input logic [3:0] e);
    wr(cdr_pkg::ADDR_DIAG, dv);
    @(posedge clk);
    {instability_evt, tone_detect, acoustic_path_evt, network_path_evt} <= ev;
    full_duplex <= fd;
    @(posedge clk);
    {instability_evt, tone_detect, acoustic_path_evt, network_path_evt} <= 4'h0;
    @(negedge clk);
    chk("detector outputs", {28'h0, e}, {28'h0, acoustic_coef_clear, network_coef_clear,
        acoustic_coef_freeze, force_receive});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 6; i++) begin
      early = (modes[i] == 16'h8000) || (modes[i] == 16'h8006);
      warm  = (modes[i] == 16'h0006) || (modes[i] == 16'h8006);
      a0 = n_acl;
      n0 = n_ncl;
      p0 = n_app;
      boot(modes[i], i != 0, !early);
      chk("start time class", {31'h0, early}, {31'h0, el < CTO - 4});
      if (!early) chk("timed start", 32'h1, {31'h0, el >= CTO && el <= CTO + 4});
      chk("warm flag", {31'h0, warm}, {31'h0, reset_was_warm});
      chk("apply pulse", 32'h1, n_app - p0);
      chk("coef clears", {30'h0, !warm, !warm},
          {30'h0, n_acl - a0 == 1, n_ncl - n0 == 1});
      rd_chk("diag default", cdr_pkg::ADDR_DIAG, 16'h0000);
      rd_chk("reg0 value", cdr_pkg::ADDR_REG0,
             (modes[i] == 16'h8000) ? 16'h8000 : 16'h0000);
      rd_chk("reg3 value", cdr_pkg::ADDR_REG3,
             (modes[i] == 16'h8006) ? 16'h8006 : 16'h0000);
      wr(cdr_pkg::ADDR_REG3, 16'h0000);
      wr(cdr_pkg::ADDR_REG0, 16'h0000);
    end
    $display("test reset modes done");
    foreach (vals[i]) begin
      wr(cdr_pkg::ADDR_DIAG, vals[i]);
      rd_chk("diag readback", cdr_pkg::ADDR_DIAG, vals[i]);
      chk("diag outputs", {24'h0, vals[i][11:4]},
          {24'h0, acoustic_preemph_off, network_preemph_off,
          acoustic_canceller_off, network_canceller_off, acoustic_sidetone_level,
          network_sidetone_level});
    end
    wr(8'h20, 16'hffff);
    rd_chk("unmapped read", 8'h20, 16'h0000);
    wr(cdr_pkg::ADDR_REG0, 16'h1234);
    rd_chk("reg0 rewrite", cdr_pkg::ADDR_REG0, 16'h1234);
    p0 = n_app;
    wr(cdr_pkg::ADDR_MODE, cdr_pkg::MODE_WARM_NOW);
    rd_chk("mode reads zero", cdr_pkg::ADDR_MODE, 16'h0000);
    chk("late mode ignored", 32'h1, {31'h0, n_app == p0 && device_running === 1'b1});
    $display("test registers done");
    det(4'b1000, 16'h0000, 1'b0, 4'b1100);
    det(4'b1000, 16'h8000, 1'b0, 4'b0000);
    det(4'b0010, 16'h0000, 1'b0, 4'b1000);
    det(4'b0010, 16'h2000, 1'b0, 4'b0000);
    det(4'b0001, 16'h0000, 1'b0, 4'b0100);
    det(4'b0001, 16'h1000, 1'b0, 4'b0000);
    det(4'b0100, 16'h4000, 1'b0, 4'b0000);
    det(4'b0100, 16'h0000, 1'b1, 4'b0010);
    det(4'b0100, 16'h0000, 1'b0, 4'b1001);
    $display("test detectors done");
    test_done();
  end
endmodule
